/* File: pcs_pkg.sv */
// Constants, register map and carrier types for the processor companion supervisor
package pcs_pkg;

  // Timing base
  localparam int CLK_HZ = 20_000_000;
  localparam int STRETCH_MS = 100;
  localparam int STRETCH_CYC = CLK_HZ / 1000 * STRETCH_MS;
  localparam int WD_STEP_MS = 100;
  localparam int WD_STEP_CYC = CLK_HZ / 1000 * WD_STEP_MS;
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int CAL_HZ = 512;
  localparam int CAL_HALF_CYC = CLK_HZ / (2 * CAL_HZ);

  // Companion target address, upper five bits; value is arbitrary
  localparam logic [4:0] TARGET_ADDR_HI = 5'h1A;

  // Register offsets
  localparam logic [7:0] OFS_RTC_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAGS_KICK = 8'h09;
  localparam logic [7:0] OFS_WD_CTRL = 8'h0A;
  localparam logic [7:0] OFS_COMP_CTRL = 8'h0B;
  localparam logic [7:0] OFS_CNT_CTRL = 8'h0C;
  localparam logic [7:0] OFS_EVENT_INPUT_ONE_LO = 8'h0D;
  localparam logic [7:0] OFS_EVENT_INPUT_ONE_HI = 8'h0E;
  localparam logic [7:0] OFS_EVENT_INPUT_TWO_LO = 8'h0F;
  localparam logic [7:0] OFS_EVENT_INPUT_TWO_HI = 8'h10;
  localparam logic [7:0] OFS_SERIAL_FIRST = 8'h11;
  localparam logic [7:0] OFS_SERIAL_LAST = 8'h18;

  // Field positions
  localparam int BIT_CAL = 2;
  localparam int BIT_WD_FLAG = 7;
  localparam int BIT_POR_FLAG = 6;
  localparam logic [3:0] KICK_PATTERN = 4'hA;
  localparam int BIT_WD_EN = 7;
  localparam int BIT_LOCK = 7;
  localparam int BIT_SNAPSHOT = 3;
  localparam logic [4:0] WD_OFF_CODE = 5'h1F;

  // Reset values
  localparam logic [7:0] RST_WD_CTRL = 8'h00;
  localparam logic [2:0] RST_COMP_CTRL = 3'h0;
  localparam logic [3:0] RST_CNT_CTRL = 4'h0;
  localparam logic RST_POR_FLAG = 1'b1;

  // Watchdog control carrier
  typedef struct packed {
    logic en;
    logic [4:0] timeout;
  } pcs_wd_ctl_t;

  // Event counter control carrier
  typedef struct packed {
    logic snapshot;
    logic chain;
    logic polTwo;
    logic polOne;
  } pcs_cnt_ctl_t;

  // Target bus states
  typedef enum logic [3:0] {
    I2_IDLE, I2_ADDR, I2_ACK_ADDR, I2_PTR, I2_ACK_PTR, I2_WDATA, I2_ACK_W, I2_RDATA, I2_ACK_R
  } pcs_i2_state_t;

endpackage

/* File: pcs_supervisor.sv */
// Processor companion: reset supervisor, watchdog, event counters, serial number, bus target
// Operation
// - Reset pin driven low whenever supply is below selected trip point.
// - After supply recovers, reset stays low at least 100 ms more.
// - Serial bus ignored while reset is asserted.
// - Trip point chosen by two-bit field in companion control bits 1:0.
// - Watchdog timeout 100 ms to 3 s in 100 ms steps, minimum values.
// - Timeout field in watchdog control bits 4:0, enable at bit 7.
// - Watchdog drives reset only when enabled and timer expired.
// - With enable clear, timer runs and expiry only sets fault flag.
// - Watchdog restarts when any reset pulse ends.
// - Timeout code all ones stops the watchdog counter.
// - Pattern 1010b in kick register low nibble restarts and reloads timeout.
// - Watchdog held disabled while supply is below trip point.
// - External low on reset pin is debounced, then 100 ms reset.
// - Supply and watchdog reset flags set by hardware, cleared by software.
// - Power-fail output low below reference, hysteresis on rising input only.
// - Calibration bit replaces comparator output with 512 Hz square wave.
// - Two 16-bit event counters increment on programmed input edge.
// - Snapshot bit captures all four counter bytes for stable reads.
// - Software writes load counters; counting blocked during such write.
// - Chain bit makes one 32-bit counter driven by input one only.
// - Polarity bits 0 and 1 choose each counter's counting edge.
// - Eight serial bytes writable until lock bit set; lock never clears.
// - Companion answers at its own bus target address.
`timescale 1ns/1ps
module pcs_supervisor #(
  parameter int STRETCH_CYC = pcs_pkg::STRETCH_CYC,
  parameter int WD_STEP_CYC = pcs_pkg::WD_STEP_CYC,
  parameter int DEBOUNCE_CYC = pcs_pkg::DEBOUNCE_CYC,
  parameter int CAL_HALF_CYC = pcs_pkg::CAL_HALF_CYC,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial bus target
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic [1:0] devSel,
  // Reset pin, open drain
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOeN,
  // Supply comparators, one per trip point, high when supply below it
  input wire logic [3:0] supplyBelowTrip,
  // Power-fail comparator
  input wire logic powerfailSenseBelowRef,
  input wire logic powerfailSenseAboveHyst,
  output logic calOrPowerfailOut,
  // Event inputs
  input wire logic eventInputOne,
  input wire logic eventInputTwo
);

  localparam int RW = $clog2(STRETCH_CYC + 1);
  localparam int PW = $clog2(WD_STEP_CYC + 1);
  localparam int DW = $clog2(DEBOUNCE_CYC + 1);
  localparam int CW = $clog2(CAL_HALF_CYC + 1);

  // Register state
  logic calBit_r;
  logic porFlag_r;
  logic wdFlag_r;
  pcs_pkg::pcs_wd_ctl_t wdCtl_r;
  logic lockBit_r;
  logic [1:0] tripSel_r;
  pcs_pkg::pcs_cnt_ctl_t cntCtl_r;
  logic [CNT_W-1:0] cntOne_r;
  logic [CNT_W-1:0] cntTwo_r;
  logic [2*CNT_W-1:0] snap_r;
  logic [7:0] serial_r [8];

  // Bus target state
  pcs_pkg::pcs_i2_state_t st_r;
  pcs_pkg::pcs_i2_state_t st_nxt;
  logic [3:0] bitCnt_r;
  logic [3:0] bitCnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic readMode_r;
  logic readMode_nxt;
  logic sdaDrv_r;
  logic sdaDrv_nxt;
  logic sclQ_r;
  logic sdaQ_r;
  logic [7:0] rdData;

  // Supervisor state
  logic rstDrive_r;
  logic [RW-1:0] rstCnt_r;
  logic [RW-1:0] rstCnt_nxt;
  logic [1:0] mrSync_r;
  logic [DW-1:0] dbCnt_r;
  logic [PW-1:0] wdPre_r;
  logic [4:0] wdTicks_r;
  logic [4:0] wdLimit_r;
  logic pfLow_r;
  logic [CW-1:0] calCnt_r;
  logic calSq_r;

  // Bus line events
  wire startCond = scl && sclQ_r && sdaQ_r && !sdaIn;
  wire stopCond = scl && sclQ_r && !sdaQ_r && sdaIn;
  wire sclRise = scl && !sclQ_r;
  wire sclFall = !scl && sclQ_r;
  wire addrMatch = (shift_r[7:1] == {pcs_pkg::TARGET_ADDR_HI, devSel});

  // Register write decode
  wire wrStb = (st_r == pcs_pkg::I2_WDATA) && sclFall && (bitCnt_r == 4'h8);
  wire [7:0] wrData = shift_r;
  wire wrCal = wrStb && (ptr_r == pcs_pkg::OFS_RTC_CTRL);
  wire wrFlags = wrStb && (ptr_r == pcs_pkg::OFS_FLAGS_KICK);
  wire wrWd = wrStb && (ptr_r == pcs_pkg::OFS_WD_CTRL);
  wire wrComp = wrStb && (ptr_r == pcs_pkg::OFS_COMP_CTRL);
  wire wrCntCtl = wrStb && (ptr_r == pcs_pkg::OFS_CNT_CTRL);
  wire wrC1L = wrStb && (ptr_r == pcs_pkg::OFS_EVENT_INPUT_ONE_LO);
  wire wrC1H = wrStb && (ptr_r == pcs_pkg::OFS_EVENT_INPUT_ONE_HI);
  wire wrC2L = wrStb && (ptr_r == pcs_pkg::OFS_EVENT_INPUT_TWO_LO);
  wire wrC2H = wrStb && (ptr_r == pcs_pkg::OFS_EVENT_INPUT_TWO_HI);
  wire wrCntAny = wrC1L || wrC1H || wrC2L || wrC2H;
  wire inSerial = (ptr_r >= pcs_pkg::OFS_SERIAL_FIRST) && (ptr_r <= pcs_pkg::OFS_SERIAL_LAST);
  wire [2:0] serialIdx = 3'(ptr_r - pcs_pkg::OFS_SERIAL_FIRST);
  wire wrSerial = wrStb && inSerial && !lockBit_r;
  wire kick = wrFlags && (wrData[3:0] == pcs_pkg::KICK_PATTERN);
  wire snapTake = wrCntCtl && wrData[pcs_pkg::BIT_SNAPSHOT];

  // Supply and reset sources
  wire lowSupply = supplyBelowTrip[tripSel_r];
  wire rstEnded = rstDrive_r && !lowSupply && (rstCnt_nxt == '0);
  wire wdStopped = (wdCtl_r.timeout == pcs_pkg::WD_OFF_CODE);
  wire wdRun = !lowSupply && !rstDrive_r && !wdStopped;
  wire wdTick = wdRun && (wdPre_r == PW'(WD_STEP_CYC - 1));
  wire [4:0] wdLimitEff = (wdLimit_r == 5'h00) ? 5'h01 : wdLimit_r;
  wire wdExpire = wdTick && (wdTicks_r + 5'h01 >= wdLimitEff);
  wire wdReset = wdExpire && wdCtl_r.en;
  wire mrLow = !mrSync_r[1] && !rstDrive_r;
  wire mrFire = mrLow && (dbCnt_r == DW'(DEBOUNCE_CYC - 1));

  // Event edge detection, one lane per input
  logic [1:0] evRaw;
  logic [1:0] evPol;
  logic [1:0] evEdge;
  assign evRaw = {eventInputTwo, eventInputOne};
  assign evPol = {cntCtl_r.polTwo, cntCtl_r.polOne};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ev
      logic [2:0] sync_r;
      // Two-stage sync, third stage only feeds the edge compare
      always_ff @(posedge clk)
      begin
        if (srst)
          sync_r <= 3'h0;
        else
          sync_r <= {sync_r[1:0], evRaw[gi]};
      end
      assign evEdge[gi] = evPol[gi] ? (sync_r[1] && !sync_r[2]) : (!sync_r[1] && sync_r[2]);
    end
  endgenerate

  // Counter next values; a write in progress blocks counting
  wire cntBlock = wrCntAny;
  wire incOne = evEdge[0] && !cntBlock;
  wire incTwo = evEdge[1] && !cntBlock && !cntCtl_r.chain;
  wire [2*CNT_W-1:0] chainSum = {cntTwo_r, cntOne_r} + (2*CNT_W)'(incOne);

  // Stretch counter: reload while any source is active, else count down
  always_comb
  begin
    rstCnt_nxt = rstCnt_r;
    if (lowSupply || wdReset || mrFire)
      rstCnt_nxt = RW'(STRETCH_CYC);
    else if (rstCnt_r != '0)
      rstCnt_nxt = rstCnt_r - RW'(1);
  end

  // Reset pin driver
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rstCnt_r <= RW'(STRETCH_CYC);
      rstDrive_r <= 1'b1;
    end
    else
    begin
      rstCnt_r <= rstCnt_nxt;
      rstDrive_r <= lowSupply || (rstCnt_nxt != '0);
    end
  end
  assign rstPinOut = 1'b0;
  assign rstPinOeN = !rstDrive_r;

  // Manual reset sync and debounce; own drive masks the readback
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mrSync_r <= 2'h3;
      dbCnt_r <= '0;
    end
    else
    begin
      mrSync_r <= {mrSync_r[0], rstPinIn};
      dbCnt_r <= (mrLow && !mrFire) ? dbCnt_r + DW'(1) : '0;
    end
  end

  // Watchdog prescaler and tick counter
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wdPre_r <= '0;
      wdTicks_r <= 5'h00;
      wdLimit_r <= pcs_pkg::RST_WD_CTRL[4:0];
    end
    else
    begin
      if (kick)
        wdLimit_r <= wdCtl_r.timeout;
      if (kick || rstEnded || wdExpire || !wdRun)
      begin
        wdPre_r <= '0;
        wdTicks_r <= 5'h00;
      end
      else if (wdTick)
      begin
        wdPre_r <= '0;
        wdTicks_r <= wdTicks_r + 5'h01;
      end
      else
        wdPre_r <= wdPre_r + PW'(1);
    end
  end

  // Control and flag registers; hardware set beats software clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      calBit_r <= 1'b0;
      porFlag_r <= pcs_pkg::RST_POR_FLAG;
      wdFlag_r <= 1'b0;
      wdCtl_r <= pcs_wd_init();
      {lockBit_r, tripSel_r} <= pcs_pkg::RST_COMP_CTRL;
      cntCtl_r <= pcs_pkg::RST_CNT_CTRL;
    end
    else
    begin
      if (wrCal)
        calBit_r <= wrData[pcs_pkg::BIT_CAL];
      porFlag_r <= lowSupply || (wrFlags ? wrData[pcs_pkg::BIT_POR_FLAG] : porFlag_r);
      wdFlag_r <= wdExpire || (wrFlags ? wrData[pcs_pkg::BIT_WD_FLAG] : wdFlag_r);
      if (wrWd)
        wdCtl_r <= {wrData[pcs_pkg::BIT_WD_EN], wrData[4:0]};
      if (wrComp)
      begin
        lockBit_r <= lockBit_r || wrData[pcs_pkg::BIT_LOCK];
        tripSel_r <= wrData[1:0];
      end
      if (wrCntCtl)
        cntCtl_r <= wrData[3:0];
    end
  end

  function automatic pcs_pkg::pcs_wd_ctl_t pcs_wd_init();
    pcs_wd_init = {pcs_pkg::RST_WD_CTRL[pcs_pkg::BIT_WD_EN], pcs_pkg::RST_WD_CTRL[4:0]};
  endfunction

  // Event counters, snapshot and serial bytes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cntOne_r <= '0;
      cntTwo_r <= '0;
      snap_r <= '0;
    end
    else
    begin
      if (cntCtl_r.chain)
        {cntTwo_r, cntOne_r} <= chainSum;
      else
      begin
        cntOne_r <= cntOne_r + CNT_W'(incOne);
        cntTwo_r <= cntTwo_r + CNT_W'(incTwo);
      end
      if (wrC1L)
        cntOne_r[7:0] <= wrData;
      if (wrC1H)
        cntOne_r[15:8] <= wrData;
      if (wrC2L)
        cntTwo_r[7:0] <= wrData;
      if (wrC2H)
        cntTwo_r[15:8] <= wrData;
      if (snapTake)
        snap_r <= {cntTwo_r, cntOne_r};
      if (wrSerial)
        serial_r[serialIdx] <= wrData;
    end
  end

  // Power-fail comparator with rising-only hysteresis, calibration override
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pfLow_r <= 1'b0;
      calCnt_r <= '0;
      calSq_r <= 1'b0;
      calOrPowerfailOut <= 1'b1;
    end
    else
    begin
      if (powerfailSenseBelowRef)
        pfLow_r <= 1'b1;
      else if (powerfailSenseAboveHyst)
        pfLow_r <= 1'b0;
      calCnt_r <= (calCnt_r == CW'(CAL_HALF_CYC - 1)) ? '0 : calCnt_r + CW'(1);
      if (calCnt_r == CW'(CAL_HALF_CYC - 1))
        calSq_r <= !calSq_r;
      calOrPowerfailOut <= calBit_r ? calSq_r : !pfLow_r;
    end
  end

  // Read data mux; unmapped offsets read zero
  always_comb
  begin
    rdData = 8'h00;
    if (inSerial)
      rdData = serial_r[serialIdx];
    else
      case (ptr_r)
        pcs_pkg::OFS_RTC_CTRL: rdData = 8'(calBit_r) << pcs_pkg::BIT_CAL;
        pcs_pkg::OFS_FLAGS_KICK: rdData = {wdFlag_r, porFlag_r, 6'h00};
        pcs_pkg::OFS_WD_CTRL: rdData = {wdCtl_r.en, 2'h0, wdCtl_r.timeout};
        pcs_pkg::OFS_COMP_CTRL: rdData = {lockBit_r, 5'h00, tripSel_r};
        pcs_pkg::OFS_CNT_CTRL: rdData = {4'h0, cntCtl_r};
        pcs_pkg::OFS_EVENT_INPUT_ONE_LO: rdData = snap_r[7:0];
        pcs_pkg::OFS_EVENT_INPUT_ONE_HI: rdData = snap_r[15:8];
        pcs_pkg::OFS_EVENT_INPUT_TWO_LO: rdData = snap_r[23:16];
        pcs_pkg::OFS_EVENT_INPUT_TWO_HI: rdData = snap_r[31:24];
        default: rdData = 8'h00;
      endcase
  end

  // Bus target next state; a held reset or stop drops back to idle
  always_comb
  begin
    st_nxt = st_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    readMode_nxt = readMode_r;
    sdaDrv_nxt = sdaDrv_r;
    if (rstDrive_r || stopCond)
    begin
      st_nxt = pcs_pkg::I2_IDLE;
      sdaDrv_nxt = 1'b0;
    end
    else if (startCond)
    begin
      st_nxt = pcs_pkg::I2_ADDR;
      bitCnt_nxt = 4'h0;
      sdaDrv_nxt = 1'b0;
    end
    else
      unique case (st_r)
        pcs_pkg::I2_IDLE: ;
        pcs_pkg::I2_ADDR, pcs_pkg::I2_PTR, pcs_pkg::I2_WDATA:
        begin
          if (sclRise && bitCnt_r != 4'h8)
          begin
            shift_nxt = {shift_r[6:0], sdaIn};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == 4'h8)
          begin
            sdaDrv_nxt = 1'b1;
            if (st_r == pcs_pkg::I2_ADDR)
            begin
              st_nxt = addrMatch ? pcs_pkg::I2_ACK_ADDR : pcs_pkg::I2_IDLE;
              sdaDrv_nxt = addrMatch;
              readMode_nxt = shift_r[0];
            end
            else if (st_r == pcs_pkg::I2_PTR)
            begin
              st_nxt = pcs_pkg::I2_ACK_PTR;
              ptr_nxt = shift_r;
            end
            else
            begin
              st_nxt = pcs_pkg::I2_ACK_W;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        pcs_pkg::I2_ACK_ADDR, pcs_pkg::I2_ACK_PTR, pcs_pkg::I2_ACK_W:
        begin
          if (sclFall)
          begin
            bitCnt_nxt = 4'h0;
            sdaDrv_nxt = 1'b0;
            st_nxt = (st_r == pcs_pkg::I2_ACK_ADDR) ? pcs_pkg::I2_PTR : pcs_pkg::I2_WDATA;
            if (st_r == pcs_pkg::I2_ACK_ADDR && readMode_r)
            begin
              st_nxt = pcs_pkg::I2_RDATA;
              shift_nxt = rdData;
              sdaDrv_nxt = !rdData[7];
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        pcs_pkg::I2_RDATA:
        begin
          if (sclFall)
          begin
            bitCnt_nxt = bitCnt_r + 4'h1;
            shift_nxt = {shift_r[6:0], 1'b0};
            sdaDrv_nxt = !shift_r[6];
            if (bitCnt_r == 4'h7)
            begin
              st_nxt = pcs_pkg::I2_ACK_R;
              sdaDrv_nxt = 1'b0;
            end
          end
        end
        pcs_pkg::I2_ACK_R:
        begin
          if (sclRise && sdaIn)
            st_nxt = pcs_pkg::I2_IDLE;
          else if (sclFall)
          begin
            st_nxt = pcs_pkg::I2_RDATA;
            bitCnt_nxt = 4'h0;
            shift_nxt = rdData;
            sdaDrv_nxt = !rdData[7];
            ptr_nxt = ptr_r + 8'h01;
          end
        end
      endcase
  end

  // Bus target registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r <= pcs_pkg::I2_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      readMode_r <= 1'b0;
      sdaDrv_r <= 1'b0;
      sclQ_r <= 1'b1;
      sdaQ_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      readMode_r <= readMode_nxt;
      sdaDrv_r <= sdaDrv_nxt;
      sclQ_r <= scl;
      sdaQ_r <= sdaIn;
    end
  end
  assign sdaOut = 1'b0;
  assign sdaOeN = !sdaDrv_r;

endmodule

/* File: pcs_supervisor_assertions.sv */
// Port-level checker for the companion supervisor
`timescale 1ns/1ps
module pcs_supervisor_checker #(
  parameter int STRETCH_CYC = 20,
  parameter int DEBOUNCE_CYC = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus target pins
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOeN,
  // Reset pin and supply
  input wire logic rstPinIn,
  input wire logic rstPinOut,
  input wire logic rstPinOeN,
  input wire logic [3:0] supplyBelowTrip,
  // Shared output pin
  input wire logic calOrPowerfailOut
);
  int lowRun_r;
  int stretchRun_r;
  int extLow_r;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (srst);

  // Run lengths; a cause of reset restarts the stretch count
  always_ff @(posedge clk)
  begin
    lowRun_r <= rstPinOeN ? 0 : lowRun_r + 1;
    stretchRun_r <= (srst || rstPinOeN || supplyBelowTrip != 4'h0) ? 0 : stretchRun_r + 1;
    extLow_r <= (srst || rstPinIn || !rstPinOeN) ? 0 : extLow_r + 1;
  end

  chk_reset_state: assert property ($past(srst) |-> !rstPinOeN && sdaOeN && calOrPowerfailOut)
    else $error("pins not in reset state after reset");
  chk_supply_drive: assert property ((supplyBelowTrip == 4'hF) |=> !rstPinOeN)
    else $error("reset pin released while supply below every trip point");
  chk_stretch_min: assert property ($rose(rstPinOeN) |-> lowRun_r >= STRETCH_CYC - 1)
    else $error("reset pin released before the stretch ran out");
  chk_stretch_bound: assert property (stretchRun_r <= STRETCH_CYC + 3)
    else $error("reset pin held longer than the stretch");
  chk_bus_locked: assert property (!rstPinOeN [*3] |-> sdaOeN)
    else $error("data line pulled while reset is driven");
  chk_manual_bound: assert property (extLow_r <= DEBOUNCE_CYC + 4)
    else $error("external low not answered after debounce");
  chk_sda_slot: assert property ($changed(sdaOeN) && $past(rstPinOeN) && rstPinOeN |-> !scl)
    else $error("data line changed while bus clock high");
  chk_drive_zero: assert property (sdaOut == 1'b0 && rstPinOut == 1'b0)
    else $error("open drain pin drives a high level");
endmodule

bind pcs_supervisor pcs_supervisor_checker #(.STRETCH_CYC(STRETCH_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) chk (
  .clk(clk), .srst(srst), .scl(scl), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .rstPinIn(rstPinIn),
  .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN), .supplyBelowTrip(supplyBelowTrip),
  .calOrPowerfailOut(calOrPowerfailOut));

/* File: pcs_host_model.sv */
// Host model: bus master and pulled-up data and reset wires
`timescale 1ns/1ps
module pcs_host_model (
  // Clock
  input wire logic clk,
  // Device enables, active low
  input wire logic sdaOeN,
  input wire logic rstPinOeN,
  // Reset switch, low when pressed
  input wire logic manualRstN,
  // Resolved wires
  output logic scl,
  output logic sdaWire,
  output logic rstWire
);
  logic sdaDrv;
  logic ack;

  // Pull-ups: a wire is low only while some party pulls it
  assign sdaWire = sdaDrv & sdaOeN;
  assign rstWire = rstPinOeN & manualRstN;

  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    ack = 1'b1;
  end

  // Start or stop: data set up while the clock line is low, then moved while it is high
  task automatic cond(input logic from, input logic to);
    scl = 1'b0;
    @(negedge clk);
    sdaDrv = from;
    repeat (3) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    sdaDrv = to;
    repeat (4) @(negedge clk);
  endtask

  // One bit slot, four clocks a phase for clean sampling
  task automatic bitx(input logic b, output logic got);
    scl = 1'b0;
    @(negedge clk);
    sdaDrv = b;
    repeat (3) @(negedge clk);
    scl = 1'b1;
    repeat (2) @(negedge clk);
    got = sdaWire;
    repeat (2) @(negedge clk);
  endtask

  task automatic sendByte(input logic [7:0] d, input logic m, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(m, a);
    if (a)
      ack = 1'b0;
  endtask

  // Pointer write then data bytes, low byte first
  task automatic xfer(input logic [6:0] dev, input logic [7:0] ofs, input logic [15:0] d, input int n);
    logic [7:0] q;
    ack = 1'b1;
    cond(1'b1, 1'b0);
    sendByte({dev, 1'b0}, 1'b1, q);
    sendByte(ofs, 1'b1, q);
    for (int i = 0; i < n; i++)
      sendByte(d[8*i +: 8], 1'b1, q);
    cond(1'b0, 1'b1);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d);
    xfer(dev, ofs, {8'h00, d}, 1);
  endtask

  task automatic wr16(input logic [6:0] dev, input logic [7:0] ofs, input logic [15:0] d);
    xfer(dev, ofs, d, 2);
  endtask

  // Single byte read ended by a refusal from the master
  task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] q);
    logic keep;
    xfer(dev, ofs, 16'h0000, 0);
    cond(1'b1, 1'b0);
    sendByte({dev, 1'b1}, 1'b1, q);
    keep = ack;
    sendByte(8'hFF, 1'b1, q);
    ack = keep;
    cond(1'b0, 1'b1);
  endtask
endmodule

/* File: tb_pcs_supervisor.sv */
// Self-checking bench for the companion supervisor
`timescale 1ns/1ps
module tb_pcs_supervisor;
  localparam int STR = 20;
  localparam logic [6:0] DEV = {pcs_pkg::TARGET_ADDR_HI, 2'h2};
  logic clk, srst, scl, sdaWire, sdaOut, sdaOeN, rstWire, rstPinOut, rstPinOeN;
  logic pfBelow, pfAbove, calOut, evOne, evTwo, manualRstN, prevOeN;
  logic [3:0] supplyBelowTrip;
  int fails = 0;
  int comparisons = 0;
  int rstFalls = 0;

  pcs_supervisor #(.STRETCH_CYC(STR), .WD_STEP_CYC(10), .DEBOUNCE_CYC(4), .CAL_HALF_CYC(5)) DUT (
    .clk(clk), .srst(srst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .devSel(2'h2), .rstPinIn(rstWire), .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN),
    .supplyBelowTrip(supplyBelowTrip), .powerfailSenseBelowRef(pfBelow),
    .powerfailSenseAboveHyst(pfAbove), .calOrPowerfailOut(calOut),
    .eventInputOne(evOne), .eventInputTwo(evTwo));

  pcs_host_model host (
    .clk(clk), .sdaOeN(sdaOeN), .rstPinOeN(rstPinOeN), .manualRstN(manualRstN),
    .scl(scl), .sdaWire(sdaWire), .rstWire(rstWire));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Counts each start of reset drive
  always @(negedge clk)
  begin
    if (prevOeN === 1'b1 && rstPinOeN === 1'b0)
      rstFalls++;
    prevOeN = rstPinOeN;
  end

  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    host.wr(DEV, ofs, d);
  endtask

  task automatic expectReg(input logic [7:0] ofs, input logic [7:0] mask, input logic [7:0] exp, input string what);
    logic [7:0] q;
    host.rd(DEV, ofs, q);
    check(what, q & mask, exp);
  endtask

  // Bounded wait for the reset drive to reach a level
  task automatic waitPin(input logic level, input int limit, output int n);
    n = 0;
    while (rstPinOeN !== level)
    begin
      @(negedge clk);
      n++;
      if (n > limit)
      begin
        fails++;
        conclude();
      end
    end
  endtask

  task automatic pulses(input int n1, input int n2);
    for (int i = 0; i < 2; i++)
    begin
      evOne = (i < n1);
      evTwo = (i < n2);
      repeat (4) @(negedge clk);
      evOne = 1'b0;
      evTwo = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask

  task automatic powerUp();
    int n;
    waitPin(1'b1, 40, n);
    check("powerup stretch", n >= STR - 2 && n <= STR + 4, 1);
    expectReg(8'h09, 8'hC0, 8'hC0, "source flags");
    host.wr(DEV ^ 7'h01, 8'h0B, 8'h03);
    check("foreign ack", host.ack, 0);
    expectReg(8'h0B, 8'hFF, 8'h00, "foreign write");
    expectReg(8'h20, 8'hFF, 8'h00, "unmapped");
    check("fault resets", rstFalls, 0);
  endtask

  task automatic watchdog();
    int n;
    wr(8'h0A, 8'h1F);
    wr(8'h09, 8'h0A);
    wr(8'h09, 8'h00);
    repeat (400) @(negedge clk);
    expectReg(8'h09, 8'hC0, 8'h00, "stopped timer");
    wr(8'h0A, 8'h1E);
    host.wr16(DEV, 8'h09, 16'h9E0A);
    waitPin(1'b0, 400, n);
    check("expiry time", n >= 170 && n <= 230, 1);
    waitPin(1'b1, 40, n);
    check("watchdog stretch", n >= STR - 2 && n <= STR + 4, 1);
    repeat (250) @(negedge clk);
    check("restart period", rstFalls, 1);
    waitPin(1'b0, 80, n);
    waitPin(1'b1, 40, n);
    wr(8'h0A, 8'h1F);
    expectReg(8'h09, 8'h80, 8'h80, "watchdog flag");
    wr(8'h09, 8'h0A);
    check("disabled expiry", rstFalls, 2);
  endtask

  task automatic supply();
    int n;
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h0B, k[7:0]);
      supplyBelowTrip = 4'hF << (k + 1);
      repeat (10) @(negedge clk);
      check("above trip", rstPinOeN, 1);
      supplyBelowTrip = 4'hF << k;
      repeat (30) @(negedge clk);
      check("below trip", rstPinOeN, 0);
      host.wr(DEV, 8'h0B, 8'h03);
      check("locked bus", host.ack, 0);
      supplyBelowTrip = 4'h0;
      waitPin(1'b1, 40, n);
      check("supply stretch", n >= STR - 1 && n <= STR + 4, 1);
      expectReg(8'h0B, 8'h03, k[7:0], "trip select");
      expectReg(8'h09, 8'h40, 8'h40, "supply flag");
    end
    wr(8'h0B, 8'h00);
  endtask

  task automatic manual();
    int n;
    int f0;
    f0 = rstFalls;
    manualRstN = 1'b0;
    repeat (2) @(negedge clk);
    manualRstN = 1'b1;
    repeat (10) @(negedge clk);
    check("glitch filtered", rstFalls, f0);
    manualRstN = 1'b0;
    waitPin(1'b0, 12, n);
    manualRstN = 1'b1;
    waitPin(1'b1, 40, n);
    check("manual stretch", n >= STR - 2 && n <= STR + 4, 1);
  endtask

  task automatic powerFail();
    int edges;
    logic last;
    pfBelow = 1'b1;
    pfAbove = 1'b0;
    repeat (4) @(negedge clk);
    check("power fail", calOut, 0);
    pfBelow = 1'b0;
    repeat (4) @(negedge clk);
    check("hysteresis", calOut, 0);
    pfAbove = 1'b1;
    repeat (4) @(negedge clk);
    check("power good", calOut, 1);
    wr(8'h00, 8'h04);
    pfBelow = 1'b1;
    pfAbove = 1'b0;
    edges = 0;
    last = calOut;
    repeat (100)
    begin
      @(negedge clk);
      edges += (calOut !== last);
      last = calOut;
    end
    check("cal edges", edges >= 19 && edges <= 21, 1);
    wr(8'h00, 8'h00);
    pfBelow = 1'b0;
    pfAbove = 1'b1;
  endtask

  task automatic counters();
    wr(8'h0C, 8'h01);
    host.wr16(DEV, 8'h0D, 16'h00FF);
    pulses(2, 2);
    pulses(1, 0);
    {evOne, evTwo} = 2'h3;
    wr(8'h0C, 8'h09);
    pulses(1, 1);
    expectReg(8'h0D, 8'hFF, 8'h03, "count one low");
    expectReg(8'h0E, 8'hFF, 8'h01, "count one high");
    expectReg(8'h0F, 8'hFF, 8'h02, "count two");
    wr(8'h0C, 8'h05);
    host.wr16(DEV, 8'h0D, 16'hFFFF);
    pulses(1, 2);
    wr(8'h0C, 8'h0D);
    expectReg(8'h0D, 8'hFF, 8'h00, "chained low");
    expectReg(8'h0F, 8'hFF, 8'h04, "chained carry");
  endtask

  task automatic serial();
    wr(8'h11, 8'h5A);
    wr(8'h0B, 8'h80);
    wr(8'h11, 8'hA5);
    wr(8'h0B, 8'h00);
    expectReg(8'h11, 8'hFF, 8'h5A, "locked byte");
    expectReg(8'h0B, 8'h80, 8'h80, "lock sticks");
  endtask

  initial
  begin
    srst = 1'b1;
    supplyBelowTrip = 4'h0;
    pfBelow = 1'b0;
    pfAbove = 1'b1;
    evOne = 1'b0;
    evTwo = 1'b0;
    manualRstN = 1'b1;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    powerUp();
    watchdog();
    supply();
    manual();
    powerFail();
    counters();
    serial();
    conclude();
  end
endmodule
